// ===== hdl/wdc_pkg.sv
// constants for the watchdog configuration word decoder
package wdc_pkg;
  // register map, byte addresses
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h10;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h14;
  localparam logic [4:0] ADDR_PROG_MASK = 5'h18;
  // configuration word layout
  localparam int CFG_WIDTH = 24;
  localparam logic [23:0] CFG_RESET = 24'hffffff;
  localparam logic [23:0] CFG_IMPL_MASK = 24'h006bff;
  localparam int POS_CLK_SEL = 13;
  localparam int POS_CMX = 11;
  localparam int POS_WIN = 8;
  localparam int POS_WIN_OFF = 7;
  localparam int POS_EN = 5;
  localparam int POS_PRE = 4;
  localparam int POS_POST = 0;
  // clock select codes
  localparam logic [1:0] CLK_PERIPH = 2'h0;
  localparam logic [1:0] CLK_SECONDARY_OSC_CLOCK = 2'h1;
  localparam logic [1:0] CLK_FAST = 2'h2;
  localparam logic [1:0] CLK_LOW_POWER_RC_CLOCK = 2'h3;
  // enable policy codes
  localparam logic [1:0] EN_OFF = 2'h0;
  localparam logic [1:0] EN_ACTIVE = 2'h1;
  localparam logic [1:0] EN_SOFT = 2'h2;
  localparam logic [1:0] EN_ON = 2'h3;
  // window share in eighths of the period
  localparam logic [3:0] WIN_25 = 4'h2;
  localparam logic [3:0] WIN_37 = 4'h3;
  localparam logic [3:0] WIN_50 = 4'h4;
  localparam logic [3:0] WIN_75 = 4'h6;
  // prescale ratios
  localparam logic [7:0] PRE_128 = 8'h80;
  localparam logic [7:0] PRE_32 = 8'h20;
  // irq bits
  localparam int IRQ_PROG = 0;
  localparam int IRQ_REFUSE = 1;
  localparam int IRQ_SRC = 2;
  localparam int IRQ_W = 3;
endpackage

// ===== hdl/wdc_clk_decode.sv
// watchdog clock source selection from config bits and system state
`timescale 1ns/10ps
module wdc_clk_decode (
  // config fields
  input wire logic clock_mux_on_i,
  input wire logic [1:0] clock_select_i,
  input wire logic window_mode_off_i,
  // system state
  input wire logic sys_on_low_power_rc_clock_i,
  input wire logic sleeping_i,
  // chosen source
  output logic [1:0] source_o
);
  always_comb begin
    source_o = wdc_pkg::CLK_LOW_POWER_RC_CLOCK;
    if (clock_mux_on_i) begin
      case (clock_select_i)
        wdc_pkg::CLK_LOW_POWER_RC_CLOCK: source_o = wdc_pkg::CLK_LOW_POWER_RC_CLOCK;
        wdc_pkg::CLK_SECONDARY_OSC_CLOCK: source_o = wdc_pkg::CLK_SECONDARY_OSC_CLOCK;
        wdc_pkg::CLK_FAST: begin
          if (!window_mode_off_i && !sys_on_low_power_rc_clock_i && !sleeping_i) begin
            source_o = wdc_pkg::CLK_FAST;
          end
        end
        wdc_pkg::CLK_PERIPH: begin
          if (!sys_on_low_power_rc_clock_i && !sleeping_i) begin
            source_o = wdc_pkg::CLK_PERIPH;
          end
        end
        default: source_o = wdc_pkg::CLK_LOW_POWER_RC_CLOCK;
      endcase
    end
    // mux off leaves the default low-power rc, select ignored
  end
endmodule // wdc_clk_decode

// ===== hdl/wdc_top.sv
// watchdog configuration word store and decoder with avalon-mm slave
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module wdc_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // system state
  input wire logic sys_on_low_power_rc_clock_i,
  input wire logic sleeping_i,
  // decoded configuration
  output logic wd_enabled_o,
  output logic [1:0] wd_clock_source_o,
  output logic window_active_o,
  output logic [3:0] window_eighths_o,
  output logic [7:0] prescale_ratio_o,
  output logic [3:0] wd_postscale_select_o,
  // interrupt
  output logic irq_o
);
  logic [23:0] watchdog_config_word_reg;
  logic [23:0] programmed_reg;
  logic software_wd_enable_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_en_reg;
  logic ack_reg;
  logic [1:0] src_now;
  logic [1:0] src_last_reg;
  logic [23:0] cfg_read;
  logic wr_hit;
  logic [23:0] wr_bits;
  logic [23:0] prog_try;
  logic [23:0] prog_ok;
  logic refused;
  logic [2:0] irq_set;
  logic [31:0] rd_next;
  logic en_next;
  logic [3:0] win_next;

  // one wait state per access: the answer always arrives on the second edge
  assign wr_hit = avs_write_i && !ack_reg;

  // byte lanes 0 to 2 each gate their own byte of the config word; lane 3 gates none
  always_comb begin
    for (int i = 0; i < wdc_pkg::CFG_WIDTH; i++) begin
      wr_bits[i] = avs_byteenable_i[i / 8];
    end
  end

  assign cfg_read = watchdog_config_word_reg | ~wdc_pkg::CFG_IMPL_MASK;

  // a bit may go from one to zero once; later changes are refused
  assign prog_try = wr_bits & wdc_pkg::CFG_IMPL_MASK & (avs_writedata_i[23:0] ^ watchdog_config_word_reg);
  assign prog_ok = prog_try & ~programmed_reg;
  assign refused = wr_hit && (avs_address_i == wdc_pkg::ADDR_CONFIG[4:0]) && |(prog_try & programmed_reg);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      watchdog_config_word_reg <= wdc_pkg::CFG_RESET;
      programmed_reg <= 24'h000000;
    end else if (wr_hit && avs_address_i == wdc_pkg::ADDR_CONFIG[4:0]) begin
      watchdog_config_word_reg <= watchdog_config_word_reg ^ prog_ok;
      programmed_reg <= programmed_reg | prog_ok;
    end
  end

  // software enable only has meaning under the hand-over policy
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      software_wd_enable_reg <= 1'b0;
    end else if (wr_hit && avs_address_i == wdc_pkg::ADDR_CTRL[4:0] && avs_byteenable_i[0]) begin
      software_wd_enable_reg <= avs_writedata_i[0];
    end
  end

  wdc_clk_decode u_clk_decode (
    .clock_mux_on_i(watchdog_config_word_reg[wdc_pkg::POS_CMX]),
    .clock_select_i(watchdog_config_word_reg[wdc_pkg::POS_CLK_SEL +: 2]),
    .window_mode_off_i(watchdog_config_word_reg[wdc_pkg::POS_WIN_OFF]),
    .sys_on_low_power_rc_clock_i(sys_on_low_power_rc_clock_i),
    .sleeping_i(sleeping_i),
    .source_o(src_now)
  );

  always_comb begin
    case (watchdog_config_word_reg[wdc_pkg::POS_EN +: 2])
      wdc_pkg::EN_ON: en_next = 1'b1;
      wdc_pkg::EN_SOFT: en_next = software_wd_enable_reg;
      wdc_pkg::EN_ACTIVE: en_next = !sleeping_i;
      wdc_pkg::EN_OFF: en_next = 1'b0;
      default: en_next = 1'b0;
    endcase
  end

  always_comb begin
    case (watchdog_config_word_reg[wdc_pkg::POS_WIN +: 2])
      2'h3: win_next = wdc_pkg::WIN_25;
      2'h2: win_next = wdc_pkg::WIN_37;
      2'h1: win_next = wdc_pkg::WIN_50;
      2'h0: win_next = wdc_pkg::WIN_75;
      default: win_next = wdc_pkg::WIN_75;
    endcase
  end

  // decoded outputs registered so the outputs come from flops
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wd_enabled_o <= 1'b1;
      wd_clock_source_o <= wdc_pkg::CLK_LOW_POWER_RC_CLOCK;
      window_active_o <= 1'b0;
      window_eighths_o <= wdc_pkg::WIN_25;
      prescale_ratio_o <= wdc_pkg::PRE_128;
      wd_postscale_select_o <= 4'hf;
    end else begin
      wd_enabled_o <= en_next;
      wd_clock_source_o <= src_now;
      window_active_o <= !watchdog_config_word_reg[wdc_pkg::POS_WIN_OFF];
      window_eighths_o <= win_next;
      prescale_ratio_o <= watchdog_config_word_reg[wdc_pkg::POS_PRE] ? wdc_pkg::PRE_128 : wdc_pkg::PRE_32;
      wd_postscale_select_o <= watchdog_config_word_reg[wdc_pkg::POS_POST +: 4];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      src_last_reg <= wdc_pkg::CLK_LOW_POWER_RC_CLOCK;
    end else begin
      src_last_reg <= src_now;
    end
  end

  // events: a bit programmed, a program attempt refused, clock source changed
  assign irq_set[wdc_pkg::IRQ_PROG] = wr_hit && avs_address_i == wdc_pkg::ADDR_CONFIG[4:0] && |prog_ok;
  assign irq_set[wdc_pkg::IRQ_REFUSE] = refused;
  assign irq_set[wdc_pkg::IRQ_SRC] = src_now != src_last_reg;

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_stat_reg <= 3'h0;
    end else if (wr_hit && avs_address_i == wdc_pkg::ADDR_IRQ_CLR[4:0] && avs_byteenable_i[0]) begin
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata_i[2:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_en_reg <= 3'h0;
    end else if (wr_hit && avs_address_i == wdc_pkg::ADDR_IRQ_EN[4:0] && avs_byteenable_i[0]) begin
      irq_en_reg <= avs_writedata_i[2:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_stat_reg | irq_set) & irq_en_reg);
    end
  end

  always_comb begin
    rd_next = 32'h00000000;
    case (avs_address_i)
      wdc_pkg::ADDR_CONFIG[4:0]: rd_next = {8'h00, cfg_read};
      wdc_pkg::ADDR_CTRL[4:0]: rd_next = {31'h00000000, software_wd_enable_reg};
      wdc_pkg::ADDR_STATUS[4:0]: rd_next = {20'h00000, src_now, en_next, !watchdog_config_word_reg[wdc_pkg::POS_WIN_OFF],
        win_next, 4'h0};
      wdc_pkg::ADDR_IRQ_STAT[4:0]: rd_next = {29'h00000000, irq_stat_reg};
      wdc_pkg::ADDR_IRQ_EN[4:0]: rd_next = {29'h00000000, irq_en_reg};
      wdc_pkg::ADDR_PROG_MASK[4:0]: rd_next = {8'h00, programmed_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_reg) begin
      avs_readdata_o <= rd_next;
    end
  end
endmodule // wdc_top

// ===== bench/wdc_top_properties.sv
// concurrent checks on the ports of the watchdog configuration decoder
`timescale 1ns/10ps
module wdc_top_properties (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // system state and decode
  input wire logic sys_on_low_power_rc_clock_i,
  input wire logic sleeping_i,
  input wire logic [1:0] wd_clock_source_o,
  input wire logic window_active_o,
  input wire logic [3:0] window_eighths_o,
  input wire logic [7:0] prescale_ratio_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_one_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  property p_ack_short; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_ack_short: assert property (p_ack_short) else $error("waitrequest low too long");
  property p_ack_cause; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_pad_ones;
    !avs_waitrequest_o && avs_read_i && avs_address_i == 5'h00 |->
      avs_readdata_o[23:15] == 9'h1ff && avs_readdata_o[12] && avs_readdata_o[10];
  endproperty
  a_pad_ones: assert property (p_pad_ones) else $error("unused config bit read zero");
  property p_slow_src; $past(sys_on_low_power_rc_clock_i || sleeping_i) |-> wd_clock_source_o inside {2'h1, 2'h3}; endproperty
  a_slow_src: assert property (p_slow_src) else $error("fast source while asleep or on rc");
  property p_fast_win; wd_clock_source_o == 2'h2 |-> window_active_o; endproperty
  a_fast_win: assert property (p_fast_win) else $error("fast rc without window mode");
  property p_win_code; window_eighths_o inside {4'h2, 4'h3, 4'h4, 4'h6}; endproperty
  a_win_code: assert property (p_win_code) else $error("bad window share");
  property p_pre_code; prescale_ratio_o inside {8'h80, 8'h20}; endproperty
  a_pre_code: assert property (p_pre_code) else $error("bad prescale ratio");
  c_cfg_read: cover property (!avs_waitrequest_o && avs_read_i && avs_address_i == 5'h00);
  c_fast: cover property (wd_clock_source_o == 2'h2);
  c_irq: cover property (irq_o);
endmodule // wdc_top_properties
bind wdc_top wdc_top_properties u_wdc_top_properties (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .sys_on_low_power_rc_clock_i, .sleeping_i, .wd_clock_source_o,
  .window_active_o, .window_eighths_o, .prescale_ratio_o, .irq_o);

// ===== bench/wdc_top_tb_top.sv
// register-level testbench for the watchdog configuration decoder
`timescale 1ns/10ps
module wdc_top_tb_top;
  logic sys_clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0, sys_on_low_power_rc_clock_i = 0, sleeping_i = 0;
  logic [4:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, rdat;
  logic [3:0] avs_byteenable_i = 4'hf, window_eighths_o, wd_postscale_select_o;
  logic avs_waitrequest_o, wd_enabled_o, window_active_o, irq_o;
  logic [1:0] wd_clock_source_o;
  logic [7:0] prescale_ratio_o;
  logic [23:0] cfg;
  int bad_count = 0, num_checks = 0;
  wdc_top u_wdc_top (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .sys_on_low_power_rc_clock_i, .sleeping_i, .wd_enabled_o,
    .wd_clock_source_o, .window_active_o, .window_eighths_o, .prescale_ratio_o, .wd_postscale_select_o, .irq_o);
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // no fixed latency assumed: hold until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) bad_count++;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // reset also clears the programming history, so each pass programs afresh
  task automatic do_reset;
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    do_reset();
    xfer(0, 5'h00, 0);
    chk(rdat, 32'h00ffffff);
    chk({wd_enabled_o, wd_clock_source_o, window_active_o, window_eighths_o, prescale_ratio_o,
      wd_postscale_select_o}, {1'b1, 2'h3, 1'b0, 4'h2, 8'h80, 4'hf});
    for (int i = 3; i >= 0; i--) begin
      cfg = 24'hff9c05 | (i << 13) | (i << 8) | (i << 5) | (i[0] << 4);
      do_reset();
      xfer(1, 5'h00, {8'h0, cfg});
      xfer(1, 5'h04, {31'h0, !i[0]});
      xfer(0, 5'h00, 0);
      chk(rdat, {8'h0, cfg});
      settle();
      chk(wd_clock_source_o, i);
      chk(window_eighths_o, (i == 0) ? 6 : 5 - i);
      chk(prescale_ratio_o, i[0] ? 8'h80 : 8'h20);
      chk({window_active_o, wd_postscale_select_o}, 5'h15);
      chk(wd_enabled_o, i != 0);
      sleeping_i <= 1'b1;
      settle();
      chk(wd_clock_source_o, (i == 1) ? 1 : 3);
      chk(wd_enabled_o, i[1]);
      sleeping_i <= 1'b0;
      sys_on_low_power_rc_clock_i <= 1'b1;
      settle();
      chk(wd_clock_source_o, (i == 1) ? 1 : 3);
      sys_on_low_power_rc_clock_i <= 1'b0;
    end
    // trying to undo programmed bits must leave the word alone
    xfer(1, 5'h00, 32'h00ffffff);
    xfer(0, 5'h00, 0);
    chk(rdat, 32'h00ff9c05);
    xfer(0, 5'h0c, 0);
    chk(rdat[1], 1'b1);
    chk(irq_o, 1'b0);
    xfer(1, 5'h10, 32'h2);
    settle();
    chk(irq_o, 1'b1);
    xfer(1, 5'h14, 32'h2);
    settle();
    chk(irq_o, 1'b0);
    xfer(0, 5'h14, 0);
    chk(rdat, 0);
    xfer(0, 5'h1c, 0);
    chk(rdat, 0);
    xfer(1, 5'h00, 32'h00ff9405);
    xfer(0, 5'h00, 0);
    chk(rdat, 32'h00ff9405);
    xfer(0, 5'h18, 0);
    chk(rdat, 32'h00006bfa);
    settle();
    chk(wd_clock_source_o, 2'h3);
    xfer(0, 5'h08, 0);
    chk(rdat, 32'h00000d60);
    results();
  end
endmodule // wdc_top_tb_top
